// *** core/nvm_security_and_clock_divider.sv ***
/*
 Security gate, backdoor key unlock, EEPROM page mapping and program/erase
 timebase divider for an on-chip nonvolatile memory controller.
 Assumes the command sequencer reports blank check results and drives
 sector erase requests; nonvolatile option bytes are stable during reset.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module nvm_security_and_clock_divider (
    input  wire logic                   sys_clk_in,
    input  wire logic                   reset_n_in,
    input  wire nvm_sec_pkg::reg_req_t  reg_req_in,
    input  wire logic                   reg_from_debug_in,
    output logic [7:0]                  reg_rdata_out,
    input  wire logic [7:0]             nonvolatile_options_byte_in,
    input  wire logic [7:0]             nonvolatile_protect_in,
    input  wire logic [63:0]            stored_unlock_key_in,
    input  wire logic                   background_pin_in,
    input  wire nvm_sec_pkg::mem_req_t  mem_req_in,
    input  wire logic [7:0]             mem_rdata_in,
    output logic                        mem_wr_out,
    output logic                        mem_key_swallow_out,
    output logic [7:0]                  mem_rdata_out,
    input  wire logic                   blank_check_done_in,
    input  wire logic                   flash_blank_in,
    input  wire logic                   ee_erase_req_in,
    input  wire logic [3:0]             ee_sector_in,
    output logic [2*nvm_sec_pkg::EE_PAGE_BYTES-1:0] ee_erase_mask_out,
    output logic                        eeprom_page_select_out,
    output logic                        secure_out,
    output logic                        debug_enable_allowed_out,
    output logic                        active_background_out,
    output logic                        program_erase_enable_out,
    output logic                        memory_timebase_pulse_out
);
    localparam int EE_ERASE_W = 2 * nvm_sec_pkg::EE_PAGE_BYTES;

    logic [7:0] working_options_register_q;
    logic [7:0] working_protection_register_q;
    logic [7:0] memory_config_register_q;
    logic [7:0] nvm_clock_divider_q;
    logic       opts_loaded_q;
    logic       unlocked_q;
    logic [63:0] key_buf_q;
    logic [7:0]  key_seen_q;
    logic        key_order_ok_q;
    logic [2:0]  key_next_q;
    logic        background_pin_s1_q;
    logic        background_pin_s2_q;
    logic        background_pin_s3_q;
    logic        bg_capture_q;
    logic        active_background_q;
    logic [2:0]  pre_cnt_q;
    logic [5:0]  div_cnt_q;
    logic        pulse_q;
    logic [7:0]  rdata_q;
    logic [EE_ERASE_W-1:0] erase_mask_q;

    logic [1:0] security_state_field;
    logic       backdoor_enable_bit;
    logic       eeprom_sector_mode;
    logic       eeprom_page_select;
    logic       key_access_enable_bit;
    logic       secure;
    logic       block_access;
    logic       key_write;
    logic       key_match;
    logic       pre_tick;
    logic [7:0] options_view;
    logic [7:0] status_byte;

    function automatic logic is_secure_state(input logic [1:0] sec);
        return sec != nvm_sec_pkg::SEC_UNSECURED;
    endfunction : is_secure_state

    function automatic logic reg_hit(input nvm_sec_pkg::reg_req_t r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction : reg_hit

    assign security_state_field  = unlocked_q ? nvm_sec_pkg::SEC_UNSECURED
                                              : working_options_register_q[1:0];
    assign backdoor_enable_bit   = working_options_register_q[nvm_sec_pkg::BACKDOOR_ENABLE_BIT_BIT];
    assign eeprom_sector_mode    = working_options_register_q[nvm_sec_pkg::SECMODE_BIT];
    assign eeprom_page_select    = memory_config_register_q[nvm_sec_pkg::PAGESEL_BIT];
    assign key_access_enable_bit = memory_config_register_q[nvm_sec_pkg::KEY_ACCESS_ENABLE_BIT_BIT];
    assign secure = is_secure_state(security_state_field);

    // All eight bytes, in order, equal to the stored key
    assign key_match = backdoor_enable_bit && (&key_seen_q) && key_order_ok_q
                       && (key_buf_q == stored_unlock_key_in);
    assign options_view = {working_options_register_q[7:2], security_state_field};

    // Status view: strap, unlocked, divider loaded, secure from bit 3 down
    assign status_byte  = {4'h0, active_background_q, unlocked_q,
                           nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT], secure};

    // Block unsecured sources; secure code passes
    assign block_access = secure && mem_req_in.is_secure_mem
                          && (!mem_req_in.from_secure || mem_req_in.from_debug);
    // Key capture path; only secure code, never debug
    assign key_write = mem_req_in.valid && mem_req_in.wr && mem_req_in.is_key_loc
                       && key_access_enable_bit && backdoor_enable_bit
                       && mem_req_in.from_secure && !mem_req_in.from_debug;

    assign mem_key_swallow_out = key_write;
    assign mem_wr_out = mem_req_in.valid && mem_req_in.wr && !block_access && !key_write;
    // Combinational so the read data line up with the memory's own read data
    assign mem_rdata_out = block_access ? 8'h00 : mem_rdata_in;

    // First edge after reset is the load strobe for both option copies
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            opts_loaded_q <= 1'b0;
        end else begin
            opts_loaded_q <= 1'b1;
        end
    end

    // Options copied at reset; no software write path
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            working_options_register_q <= 8'h00;
        end else if (!opts_loaded_q) begin
            working_options_register_q <= nonvolatile_options_byte_in;
        end
    end

    // Protection copy at reset; only debug writes change it
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            working_protection_register_q <= 8'h00;
        end else if (!opts_loaded_q) begin
            working_protection_register_q <= nonvolatile_protect_in;
        end else if (reg_hit(reg_req_in, nvm_sec_pkg::REG_PROTECTION) && reg_from_debug_in) begin
            working_protection_register_q <= reg_req_in.wdata;
        end
    end

    // Page select and key access live in the config register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            memory_config_register_q <= nvm_sec_pkg::CONFIG_RESET;
        end else if (reg_hit(reg_req_in, nvm_sec_pkg::REG_CONFIG)) begin
            memory_config_register_q <= {1'b0, reg_req_in.wdata[6:5], 5'h00};
        end
    end

    // Store compare byte, first location in the top byte
    // Buffer is not cleared between attempts; the seen mask guards stale bytes
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            key_buf_q <= 64'h0000_0000_0000_0000;
        end else if (key_write) begin
            key_buf_q[8*(7-mem_req_in.key_idx) +: 8] <= mem_req_in.wdata;
        end
    end

    // Bytes seen since key access was set; a gap spoils the compare
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            key_seen_q <= 8'h00;
        end else if (!key_access_enable_bit) begin
            key_seen_q <= 8'h00;
        end else if (key_write) begin
            key_seen_q[mem_req_in.key_idx] <= 1'b1;
        end
    end

    // Out-of-order entry spoils the compare
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            key_order_ok_q <= 1'b1;
            key_next_q     <= 3'h0;
        end else if (!key_access_enable_bit) begin
            key_order_ok_q <= 1'b1;
            key_next_q     <= 3'h0;
        end else if (key_write) begin
            key_next_q <= mem_req_in.key_idx + 3'h1;
            if (mem_req_in.key_idx != key_next_q) begin
                key_order_ok_q <= 1'b0;
            end
        end
    end

    // Unlock latch held until reset
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            unlocked_q <= 1'b0;
        end else if (blank_check_done_in && flash_blank_in && opts_loaded_q) begin
            unlocked_q <= 1'b1;
        end else if (reg_hit(reg_req_in, nvm_sec_pkg::REG_CONFIG) && key_access_enable_bit
                     && !reg_req_in.wdata[nvm_sec_pkg::KEY_ACCESS_ENABLE_BIT_BIT]) begin
            // Full match on key access clear; needs enable
            // Partial or wrong key leaves state alone
            if (key_match) begin
                unlocked_q <= 1'b1;
            end
        end
    end

    // Chain runs through reset, so it holds the strap level at release
    always_ff @(posedge sys_clk_in) begin
        background_pin_s1_q <= background_pin_in;
        background_pin_s2_q <= background_pin_s1_q;
        background_pin_s3_q <= background_pin_s2_q;
    end

    // Strap caught once, on the edge after the options load
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            bg_capture_q        <= 1'b0;
            active_background_q <= 1'b0;
        end else if (!bg_capture_q && opts_loaded_q && background_pin_s2_q == background_pin_s3_q) begin
            bg_capture_q        <= 1'b1;
            active_background_q <= !background_pin_s3_q;
        end
    end

    // Flag on first write; fields write once
    // Later writes drop out so a runaway program cannot retune the timebase
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            nvm_clock_divider_q <= nvm_sec_pkg::CLKDIV_RESET;
        end else if (reg_hit(reg_req_in, nvm_sec_pkg::REG_CLOCK_DIVIDER)
                     && !nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT]) begin
            nvm_clock_divider_q <= {1'b1, reg_req_in.wdata[6:0]};
        end
    end

    // Divide-by-eight tick ahead of the divisor, or every cycle
    assign pre_tick = nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT]
                      && (!nvm_clock_divider_q[nvm_sec_pkg::PRESCALE_BIT]
                          || pre_cnt_q == nvm_sec_pkg::PRE8_COUNT[2:0]);

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            pre_cnt_q <= 3'h0;
        end else if (pre_tick) begin
            pre_cnt_q <= 3'h0;
        end else if (nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT]) begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end

    // Divisor plus one ticks per period
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            div_cnt_q <= 6'h00;
        end else if (pre_tick) begin
            if (div_cnt_q == nvm_clock_divider_q[5:0]) begin
                div_cnt_q <= 6'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 6'h01;
            end
        end
    end

    // One-cycle pulse closes each timebase period
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pre_tick && (div_cnt_q == nvm_clock_divider_q[5:0]);
        end
    end

    // Four-byte mode clears both pages; eight-byte foreground only
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            erase_mask_q <= '0;
        end else begin
            erase_mask_q <= '0;
            // No erase until the divider is loaded
            if (ee_erase_req_in && nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT]) begin
                if (!eeprom_sector_mode) begin
                    erase_mask_q[ee_sector_in[1:0]*4 +: 4] <= 4'hf;
                    erase_mask_q[nvm_sec_pkg::EE_PAGE_BYTES
                                 + ee_sector_in[1:0]*4 +: 4] <= 4'hf;
                end else begin
                    // Only the foreground page is touched
                    erase_mask_q[(eeprom_page_select ? nvm_sec_pkg::EE_PAGE_BYTES : 0)
                                 + ee_sector_in[0]*8 +: 8] <= 8'hff;
                end
            end
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
        end else if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                nvm_sec_pkg::REG_CLOCK_DIVIDER: rdata_q <= nvm_clock_divider_q;
                nvm_sec_pkg::REG_OPTIONS:       rdata_q <= options_view;
                nvm_sec_pkg::REG_CONFIG:        rdata_q <= memory_config_register_q;
                nvm_sec_pkg::REG_PROTECTION:    rdata_q <= working_protection_register_q;
                nvm_sec_pkg::REG_STATUS:        rdata_q <= status_byte;
                default:                        rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata_out             = rdata_q;
    assign ee_erase_mask_out         = erase_mask_q;
    assign eeprom_page_select_out    = eeprom_page_select;
    assign secure_out                = secure;
    // Debug module locked out while secure
    assign debug_enable_allowed_out  = !secure;
    assign active_background_out     = active_background_q;
    // Program and erase gated by divider loaded
    assign program_erase_enable_out  = nvm_clock_divider_q[nvm_sec_pkg::DIVIDER_LOADED_FLAG_BIT];
    assign memory_timebase_pulse_out = pulse_q;
endmodule : nvm_security_and_clock_divider
`default_nettype wire

// *** dv/cpu_bus_model.sv ***
/* CPU and debug side of the memory request port.
   Assumes the block answers memory requests combinationally. */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic                 sys_clk_in,
    input  wire logic [7:0]           mem_rdata_in,
    output var nvm_sec_pkg::mem_req_t mem_req_out
);
    initial mem_req_out = '0;
    task automatic key_entry(input logic [63:0] key, input logic dbg);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in);
            mem_req_out <= '{1'b1, 1'b1, !dbg, dbg, 1'b1, 1'b1, 3'(i), key[63-8*i -: 8]};
            @(posedge sys_clk_in);
            // Idle cycle keeps key bytes off adjacent bus cycles
            mem_req_out <= '0;
        end
    endtask : key_entry
    task automatic mem_read(input logic sec, input logic dbg, output logic [7:0] seen);
        @(posedge sys_clk_in);
        mem_req_out <= '{1'b1, 1'b0, sec, dbg, 1'b1, 1'b0, 3'h0, 8'h00};
        @(negedge sys_clk_in);
        seen = mem_rdata_in;
        @(posedge sys_clk_in);
        mem_req_out <= '0;
    endtask : mem_read
endmodule : cpu_bus_model
`default_nettype wire

// *** dv/nvm_sec_checker.sv ***
/* Port checker for the nvm security block.
   Assumes one bus clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module nvm_sec_checker (
    input wire logic                  sys_clk_in,
    input wire logic                  reset_n_in,
    input wire nvm_sec_pkg::reg_req_t reg_req_in,
    input wire nvm_sec_pkg::mem_req_t mem_req_in,
    input wire logic [7:0]            mem_rdata_in,
    input wire logic                  mem_wr_out,
    input wire logic                  mem_key_swallow_out,
    input wire logic [7:0]            mem_rdata_out,
    input wire logic                  ee_erase_req_in,
    input wire logic [31:0]           ee_erase_mask_out,
    input wire logic                  secure_out,
    input wire logic                  debug_enable_allowed_out,
    input wire logic                  program_erase_enable_out,
    input wire logic                  memory_timebase_pulse_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic blk;
    assign blk = mem_req_in.valid && mem_req_in.is_secure_mem && secure_out
        && (mem_req_in.from_debug || !mem_req_in.from_secure);
    blk_write_a: assert property (blk && mem_req_in.wr |-> !mem_wr_out)
        else $error("blocked write reached memory");
    blk_read_a: assert property (blk && !mem_req_in.wr |-> mem_rdata_out == 8'h00)
        else $error("blocked read returned data");
    secure_code_a: assert property (mem_req_in.valid && !mem_req_in.wr
        && mem_req_in.from_secure && !mem_req_in.from_debug |-> mem_rdata_out == mem_rdata_in)
        else $error("secure code read altered");
    debug_lock_a: assert property (secure_out |-> !debug_enable_allowed_out)
        else $error("debug allowed while secure");
    key_capture_a: assert property (mem_key_swallow_out |-> mem_req_in.wr && !mem_wr_out)
        else $error("key write also forwarded");
    key_source_a: assert property (mem_key_swallow_out
        |-> mem_req_in.from_secure && !mem_req_in.from_debug)
        else $error("key taken from unsecured source");
    div_loaded_a: assert property (reg_req_in.wr
        && reg_req_in.addr == nvm_sec_pkg::REG_CLOCK_DIVIDER |=> program_erase_enable_out [*8])
        else $error("divider write did not enable");
    pulse_gate_a: assert property (memory_timebase_pulse_out |-> program_erase_enable_out)
        else $error("timebase pulse while disabled");
    erase_size_a: assert property (ee_erase_req_in && program_erase_enable_out
        |=> $countones(ee_erase_mask_out) == 8)
        else $error("erase mask not eight bytes");
endmodule : nvm_sec_checker
bind nvm_security_and_clock_divider nvm_sec_checker chk_u (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .reg_req_in(reg_req_in), .mem_req_in(mem_req_in),
    .mem_rdata_in(mem_rdata_in), .mem_wr_out(mem_wr_out),
    .mem_key_swallow_out(mem_key_swallow_out), .mem_rdata_out(mem_rdata_out),
    .ee_erase_req_in(ee_erase_req_in), .ee_erase_mask_out(ee_erase_mask_out),
    .secure_out(secure_out), .debug_enable_allowed_out(debug_enable_allowed_out),
    .program_erase_enable_out(program_erase_enable_out),
    .memory_timebase_pulse_out(memory_timebase_pulse_out));
`default_nettype wire

// *** dv/nvm_security_and_clock_divider_test.sv ***
/* Directed bench for the nvm security block.
   Assumes the bind in the checker file and the bus model beside it. */
`timescale 1ns/1ps
`default_nettype none
module nvm_security_and_clock_divider_test;
    localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
    logic clk, rst_n, dbg_wr, bg, bdone, blank, ereq, mwr, swal, sec, dbgok, act, pee, pls, psel;
    logic [7:0] opt, mrd, rdat, mout, seen;
    logic [3:0] esec;
    logic [31:0] emask;
    nvm_sec_pkg::reg_req_t req;
    nvm_sec_pkg::mem_req_t mreq;
    int err_total = 0;
    int checks_done = 0;
    nvm_security_and_clock_divider dut_u (.sys_clk_in(clk), .reset_n_in(rst_n),
        .reg_req_in(req), .reg_from_debug_in(dbg_wr), .reg_rdata_out(rdat),
        .nonvolatile_options_byte_in(opt), .nonvolatile_protect_in(8'hFF),
        .stored_unlock_key_in(KEY), .background_pin_in(bg), .mem_req_in(mreq),
        .mem_rdata_in(mrd), .mem_wr_out(mwr), .mem_key_swallow_out(swal),
        .mem_rdata_out(mout), .blank_check_done_in(bdone), .flash_blank_in(blank),
        .ee_erase_req_in(ereq), .ee_sector_in(esec), .ee_erase_mask_out(emask),
        .eeprom_page_select_out(psel), .secure_out(sec), .debug_enable_allowed_out(dbgok),
        .active_background_out(act), .program_erase_enable_out(pee),
        .memory_timebase_pulse_out(pls));
    cpu_bus_model cpu_u (.sys_clk_in(clk), .mem_rdata_in(mout), .mem_req_out(mreq));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic do_reset(input logic [7:0] o, input logic p);
        @(posedge clk);
        rst_n <= 1'b0;
        opt <= o;
        bg <= p;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (7) @(posedge clk);
    endtask : do_reset
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        dbg_wr <= dbg;
        @(posedge clk);
        req <= '0;
        dbg_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input string nm, input logic [7:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk(nm, rdat, e);
    endtask : reg_rd
    task automatic ee_erase(input logic [3:0] s, input logic [31:0] e);
        @(posedge clk);
        ereq <= 1'b1;
        esec <= s;
        @(posedge clk);
        ereq <= 1'b0;
        @(negedge clk);
        chk("erase mask", emask, e);
    endtask : ee_erase
    task automatic key_try(input logic [63:0] k, input logic dbg, input logic e);
        reg_wr(nvm_sec_pkg::REG_CONFIG, 8'h20, 1'b0);
        cpu_u.key_entry(k, dbg);
        reg_wr(nvm_sec_pkg::REG_CONFIG, 8'h00, 1'b0);
        repeat (2) @(negedge clk);
        chk("secure after key", sec, e);
    endtask : key_try
    task automatic t_divider();
        int n;
        // 20 MHz over eight times thirteen stays in band
        reg_wr(nvm_sec_pkg::REG_CLOCK_DIVIDER, 8'h4C, 1'b0);
        reg_wr(nvm_sec_pkg::REG_CLOCK_DIVIDER, 8'h01, 1'b0);
        reg_rd(nvm_sec_pkg::REG_CLOCK_DIVIDER, "divider", 8'hCC);
        chk("prog enable", pee, 1'b1);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pls !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_total++;
            stop_test();
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pls !== 1'b1 && n < 300);
        // Prescale by eight, divisor twelve plus one
        chk("timebase period", n, 8 * 13);
        if (n >= 300) stop_test();
    endtask : t_divider
    initial begin
        rst_n = 1'b0;
        req = '0;
        dbg_wr = 1'b0;
        opt = 8'h00;
        bg = 1'b1;
        mrd = 8'hA5;
        bdone = 1'b0;
        blank = 1'b0;
        ereq = 1'b0;
        esec = 4'h0;
        // Options: key path on, erased security code, split sectors
        do_reset(8'h83, 1'b1);
        reg_rd(nvm_sec_pkg::REG_OPTIONS, "options", 8'h83);
        chk("secure", sec, 1'b1);
        chk("active bg", act, 1'b0);
        chk("debug enable", dbgok, 1'b0);
        reg_rd(nvm_sec_pkg::REG_CLOCK_DIVIDER, "divider", 8'h00);
        chk("prog enable", pee, 1'b0);
        reg_wr(nvm_sec_pkg::REG_OPTIONS, 8'h00, 1'b0);
        reg_rd(nvm_sec_pkg::REG_OPTIONS, "options", 8'h83);
        reg_wr(nvm_sec_pkg::REG_PROTECTION, 8'h12, 1'b0);
        reg_rd(nvm_sec_pkg::REG_PROTECTION, "protect", 8'hFF);
        reg_wr(nvm_sec_pkg::REG_PROTECTION, 8'h12, 1'b1);
        reg_rd(nvm_sec_pkg::REG_PROTECTION, "protect", 8'h12);
        reg_rd(4'hF, "unmapped", 8'h00);
        t_divider();
        cpu_u.mem_read(1'b0, 1'b0, seen);
        chk("unsecured read", seen, 8'h00);
        cpu_u.mem_read(1'b0, 1'b1, seen);
        chk("debug read", seen, 8'h00);
        cpu_u.mem_read(1'b1, 1'b0, seen);
        chk("secure read", seen, 8'hA5);
        key_try(KEY ^ 64'h1, 1'b0, 1'b1);
        key_try(KEY, 1'b1, 1'b1);
        key_try(KEY, 1'b0, 1'b0);
        ee_erase(4'h1, 32'h00F0_00F0);
        reg_wr(nvm_sec_pkg::REG_CONFIG, 8'h40, 1'b0);
        @(negedge clk);
        chk("page select", psel, 1'b1);
        // Key path off: only a blank flash unlocks
        do_reset(8'h03, 1'b1);
        key_try(KEY, 1'b0, 1'b1);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            bdone <= 1'b1;
            blank <= b[0];
            @(posedge clk);
            bdone <= 1'b0;
            repeat (2) @(negedge clk);
            chk("secure after blank check", sec, !b[0]);
        end
        // Unsecured code, whole sectors per page, pin low at reset
        do_reset(8'h22, 1'b0);
        chk("secure", sec, 1'b0);
        chk("active bg", act, 1'b1);
        chk("debug enable", dbgok, 1'b1);
        cpu_u.mem_read(1'b0, 1'b1, seen);
        chk("open debug read", seen, 8'hA5);
        reg_wr(nvm_sec_pkg::REG_CLOCK_DIVIDER, 8'h4C, 1'b0);
        reg_wr(nvm_sec_pkg::REG_CONFIG, 8'h40, 1'b0);
        ee_erase(4'h1, 32'hFF00_0000);
        stop_test();
    end
endmodule : nvm_security_and_clock_divider_test
`default_nettype wire

// *** include/nvm_sec_pkg.sv ***
/*
 Package for the nonvolatile memory security and clock divider block:
 register offsets, field positions, reset values, bus carrier structs.
 Assumes a single bus clock domain and byte-wide registers.
*/
package nvm_sec_pkg;
    // Register offsets on the plain register port (byte index)
    localparam logic [3:0] REG_CLOCK_DIVIDER  = 4'h0;
    localparam logic [3:0] REG_OPTIONS        = 4'h1;
    localparam logic [3:0] REG_CONFIG         = 4'h2;
    localparam logic [3:0] REG_PROTECTION     = 4'h3;
    localparam logic [3:0] REG_STATUS         = 4'h4;
    localparam logic [3:0] REG_EE_ERASE       = 4'h5;

    // Field positions
    localparam int DIVIDER_LOADED_FLAG_BIT     = 7;
    localparam int PRESCALE_BIT  = 6;
    localparam int BACKDOOR_ENABLE_BIT_BIT     = 7;
    localparam int SECMODE_BIT   = 5;
    localparam int PAGESEL_BIT   = 6;
    localparam int KEY_ACCESS_ENABLE_BIT_BIT    = 5;

    localparam logic [1:0] SEC_UNSECURED = 2'h1 << 1;
    localparam logic [7:0] CLKDIV_RESET  = 8'h00;
    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [5:0] PRE8_COUNT    = 6'h07;
    localparam logic [2:0] KEY_BYTES     = 3'h7;
    localparam int         EE_PAGE_BYTES = 16;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic        from_secure;
        logic        from_debug;
        logic        is_secure_mem;
        logic        is_key_loc;
        logic [2:0]  key_idx;
        logic [7:0]  wdata;
    } mem_req_t;
endpackage : nvm_sec_pkg
